/* hw/temp_spi_regs.vh */
// register map, reset values and field positions of the sensor port
`ifndef TEMP_SPI_REGS_VH
`define TEMP_SPI_REGS_VH

// ----------------------------------------------------------------
// register addresses (command bits 5..3)
// ----------------------------------------------------------------
`define ADDR_STATUS 3'h0
`define ADDR_CONFIG 3'h1
`define ADDR_TEMP 3'h2
`define ADDR_IDENT 3'h3
`define ADDR_CRIT 3'h4
`define ADDR_HYST 3'h5
`define ADDR_HIGH 3'h6
`define ADDR_LOW 3'h7

// ----------------------------------------------------------------
// power-on values
// ----------------------------------------------------------------
`define RST_CONFIG 8'h00
`define RST_CRIT 16'h4980
`define RST_HYST 8'h05
`define RST_HIGH 16'h2000
`define RST_LOW 16'h0500
`define RST_TEMP 16'h0000

// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define CMD_RW_BIT 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 3
`define CMD_BITS 5'h08
`define BYTE_BITS 5'h08
`define WORD_BITS 5'h10

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CFG_CT_POL_BIT 2
`define CFG_INT_POL_BIT 3
`define CFG_CMP_MODE_BIT 4
`define CFG_OPMODE_HI 6
`define CFG_OPMODE_LO 5
`define OPMODE_SHUTDOWN 2'h3
`define HYST_MSB 3

// ----------------------------------------------------------------
// interface reset and hysteresis scaling
// ----------------------------------------------------------------
`define ONES_RESET_COUNT 6'h20
`define HYST_SHIFT 7

`endif

/* hw/limit_alert.v */
// limit and critical alert logic with comparator and interrupt modes
`default_nettype none

module limit_alert (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	input wire softRst,
	// measurement
	input wire [15:0] tempValue,
	input wire tempValid,
	// limits
	input wire [15:0] upperLimit,
	input wire [15:0] lowerLimit,
	input wire [15:0] criticalLimit,
	input wire [3:0] hysteresisValue,
	// mode
	input wire cmpMode,
	input wire shutdown,
	input wire regReadPulse,
	// state
	output reg limitAlert_q,
	output reg critAlert_q
);
`include "temp_spi_regs.vh"

	// one degree is 0x80 in the register format
	wire signed [16:0] hystScaled =
		{6'h00, hysteresisValue, 7'h00};
	wire signed [16:0] tempS = {tempValue[15], tempValue};
	wire signed [16:0] upperS = {upperLimit[15], upperLimit};
	wire signed [16:0] lowerS = {lowerLimit[15], lowerLimit};
	wire signed [16:0] critS = {criticalLimit[15], criticalLimit};

	wire overUpper = tempS > upperS;
	wire underLower = tempS < lowerS;
	wire overCrit = tempS > critS;
	// hysteresis moves the release points inward
	wire belowUpperHys = tempS < (upperS - hystScaled);
	wire aboveLowerHys = tempS > (lowerS + hystScaled);
	wire belowCritHys = tempS < (critS - hystScaled);

	reg shdnPrev_q;
	wire sample = tempValid & ~shutdown;
	wire enterShdn = shutdown & ~shdnPrev_q;

	always @(posedge ref_clk) begin
		if (!rstn || softRst) begin
			limitAlert_q <= 1'b0;
			critAlert_q <= 1'b0;
			shdnPrev_q <= 1'b0;
		end else begin
			shdnPrev_q <= shutdown;
			if (cmpMode) begin
				// shutdown leaves comparator state alone
				if (sample && (overUpper || underLower)) begin
					limitAlert_q <= 1'b1;
				end else if (sample && belowUpperHys &&
						aboveLowerHys) begin
					limitAlert_q <= 1'b0;
				end
				if (sample && overCrit) begin
					critAlert_q <= 1'b1;
				end else if (sample && belowCritHys) begin
					critAlert_q <= 1'b0;
				end
			end else begin
				// a new event wins over a clearing read
				if (sample && (overUpper || underLower)) begin
					limitAlert_q <= 1'b1;
				end else if (regReadPulse || enterShdn) begin
					limitAlert_q <= 1'b0;
				end
				if (sample && overCrit) begin
					critAlert_q <= 1'b1;
				end else if (regReadPulse || enterShdn) begin
					critAlert_q <= 1'b0;
				end
			end
		end
	end

endmodule // limit_alert

`default_nettype wire

/* hw/temp_spi_port.v */
// serial register port of the temperature sensor with alert pins
`default_nettype none

module temp_spi_port #(
	// identification codes, values arbitrary
	parameter [4:0] MAKER_CODE = 5'h0a,
	parameter [2:0] REVISION = 3'h1
) (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// serial pins
	input wire csN,
	input wire sclk,
	input wire sdi,
	output reg sdo_q,
	output reg sdoOeN_q,
	// measurement from the conversion engine
	input wire [15:0] tempValue,
	input wire tempValid,
	// open-drain alert pins
	output wire intOut,
	output reg intOeN_q,
	output wire critical_alert_out,
	output reg critOeN_q
);
`include "temp_spi_regs.vh"

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function isWide;
		input [2:0] a;
		begin
			isWide = (a == `ADDR_TEMP) || (a == `ADDR_CRIT) ||
				(a == `ADDR_HIGH) || (a == `ADDR_LOW);
		end
	endfunction

	function [4:0] dataBits;
		input [2:0] a;
		begin
			dataBits = isWide(a) ? `WORD_BITS : `BYTE_BITS;
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg csMeta_q, csSync_q, csPrev_q;
	reg sclkMeta_q, sclkSync_q, sclkPrev_q;
	reg sdiMeta_q, sdiSync_q;

	always @(posedge ref_clk) begin
		if (!rstn) begin
			csMeta_q <= 1'b1;
			csSync_q <= 1'b1;
			csPrev_q <= 1'b1;
			sclkMeta_q <= 1'b1;
			sclkSync_q <= 1'b1;
			sclkPrev_q <= 1'b1;
			sdiMeta_q <= 1'b0;
			sdiSync_q <= 1'b0;
		end else begin
			csMeta_q <= csN;
			csSync_q <= csMeta_q;
			csPrev_q <= csSync_q;
			sclkMeta_q <= sclk;
			sclkSync_q <= sclkMeta_q;
			sclkPrev_q <= sclkSync_q;
			sdiMeta_q <= sdi;
			sdiSync_q <= sdiMeta_q;
		end
	end

	wire selected = ~csSync_q;
	wire sclkRise = sclkSync_q & ~sclkPrev_q;
	wire sclkFall = ~sclkSync_q & sclkPrev_q;
	wire csFall = csPrev_q & ~csSync_q;
	// edges outside a frame are ignored
	wire bitIn = selected & sclkRise;
	wire bitOut = selected & sclkFall;

	// ----------------------------------------------------------------
	// interface reset by a run of ones
	// ----------------------------------------------------------------
	reg [5:0] onesCnt_q;
	wire onesReset = bitIn & sdiSync_q &
		(onesCnt_q == `ONES_RESET_COUNT - 6'h01);

	always @(posedge ref_clk) begin
		if (!rstn) begin
			onesCnt_q <= 6'h00;
		end else if (bitIn) begin
			if (!sdiSync_q || onesReset) begin
				onesCnt_q <= 6'h00;
			end else begin
				onesCnt_q <= onesCnt_q + 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] config_q;
	reg [7:0] hyst_q;
	reg [15:0] critical_limit_setpoint_q;
	reg [15:0] upper_limit_setpoint_q;
	reg [15:0] lower_limit_setpoint_q;
	reg [15:0] tempReg_q;
	wire limitAlert;
	wire critAlert;
	wire shutdown;
	wire cmpMode;

	wire [7:0] identification = {MAKER_CODE, REVISION};

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	localparam [2:0] ST_CMD = 3'b001;
	localparam [2:0] ST_DATA = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	reg [2:0] state_q;
	reg [4:0] bitCnt_q;
	reg [15:0] rxShift_q;
	reg [15:0] txShift_q;
	reg isRead_q;
	reg [2:0] addr_q;

	wire [7:0] cmdByte = {rxShift_q[6:0], sdiSync_q};
	wire [15:0] rxWord = {rxShift_q[14:0], sdiSync_q};
	wire [2:0] cmdAddr = cmdByte[`CMD_ADDR_HI:`CMD_ADDR_LO];
	wire cmdRead = cmdByte[`CMD_RW_BIT];
	wire cmdDone = bitIn && (state_q == ST_CMD) &&
		(bitCnt_q == `CMD_BITS - 5'h01);
	wire dataDone = bitIn && (state_q == ST_DATA) &&
		(bitCnt_q == dataBits(addr_q) - 5'h01);
	wire writeCommit = dataDone & ~isRead_q & ~onesReset;

	// read value, left aligned so the top bit leaves first
	reg [15:0] readWord;
	always @* begin
		readWord = 16'h0000;
		case (cmdAddr)
			`ADDR_CONFIG: readWord = {config_q, 8'h00};
			`ADDR_TEMP: readWord = tempReg_q;
			`ADDR_IDENT: readWord = {identification, 8'h00};
			`ADDR_CRIT: readWord = critical_limit_setpoint_q;
			`ADDR_HYST: readWord = {hyst_q, 8'h00};
			`ADDR_HIGH: readWord = upper_limit_setpoint_q;
			`ADDR_LOW: readWord = lower_limit_setpoint_q;
			default: readWord = 16'h0000;
		endcase
	end

	// any register read releases an interrupt-mode alert
	wire regReadPulse = cmdDone & cmdRead & ~onesReset;

	always @(posedge ref_clk) begin
		if (!rstn || onesReset) begin
			// back to waiting for a command byte
			state_q <= ST_CMD;
			bitCnt_q <= 5'h00;
			rxShift_q <= 16'h0000;
			txShift_q <= 16'h0000;
			isRead_q <= 1'b0;
			addr_q <= `ADDR_STATUS;
		end else if (!selected) begin
			// a frame cut short is dropped here
			state_q <= ST_CMD;
			bitCnt_q <= 5'h00;
			isRead_q <= 1'b0;
		end else if (bitIn) begin
			rxShift_q <= rxWord;
			case (state_q)
				ST_CMD: begin
					if (cmdDone) begin
						state_q <= ST_DATA;
						bitCnt_q <= 5'h00;
						isRead_q <= cmdRead;
						addr_q <= cmdAddr;
						txShift_q <= readWord;
					end else begin
						bitCnt_q <= bitCnt_q + 5'h01;
					end
				end
				ST_DATA: begin
					if (dataDone) begin
						// chip select held low: next command follows
						state_q <= ST_CMD;
						bitCnt_q <= 5'h00;
					end else begin
						bitCnt_q <= bitCnt_q + 5'h01;
					end
				end
				default: begin
					state_q <= ST_CMD;
					bitCnt_q <= 5'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// serial output
	// ----------------------------------------------------------------
	// the top bit of the pending word appears on the select edge, which
	// also covers masters that lower select after their clock edge
	reg [15:0] txLive_q;
	always @(posedge ref_clk) begin
		if (!rstn || onesReset) begin
			sdo_q <= 1'b0;
			sdoOeN_q <= 1'b1;
			txLive_q <= 16'h0000;
		end else if (!selected) begin
			sdoOeN_q <= 1'b1;
		end else if (csFall) begin
			sdo_q <= txShift_q[15];
			sdoOeN_q <= 1'b0;
		end else if (cmdDone) begin
			txLive_q <= readWord;
			sdoOeN_q <= 1'b0;
		end else if (bitOut && (state_q == ST_DATA) && isRead_q) begin
			sdo_q <= txLive_q[15];
			txLive_q <= {txLive_q[14:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!rstn || onesReset) begin
			config_q <= `RST_CONFIG;
			hyst_q <= `RST_HYST;
			critical_limit_setpoint_q <= `RST_CRIT;
			upper_limit_setpoint_q <= `RST_HIGH;
			lower_limit_setpoint_q <= `RST_LOW;
		end else if (writeCommit) begin
			case (addr_q)
				`ADDR_CONFIG: config_q <= rxWord[7:0];
				`ADDR_HYST: hyst_q <= rxWord[7:0];
				`ADDR_CRIT: critical_limit_setpoint_q <= rxWord;
				`ADDR_HIGH: upper_limit_setpoint_q <= rxWord;
				`ADDR_LOW: lower_limit_setpoint_q <= rxWord;
				default: config_q <= config_q;
			endcase
		end
	end

	// the value shown to reads takes every sample and holds its last one during shutdown
	always @(posedge ref_clk) begin
		if (!rstn || onesReset) begin
			tempReg_q <= `RST_TEMP;
		end else if (tempValid && !shutdown) begin
			tempReg_q <= tempValue;
		end
	end

	// ----------------------------------------------------------------
	// alerts
	// ----------------------------------------------------------------
	assign shutdown = config_q[`CFG_OPMODE_HI:`CFG_OPMODE_LO] ==
		`OPMODE_SHUTDOWN;
	assign cmpMode = config_q[`CFG_CMP_MODE_BIT];

	limit_alert alertLogic (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.softRst(onesReset),
		.tempValue(tempValue),
		.tempValid(tempValid),
		.upperLimit(upper_limit_setpoint_q),
		.lowerLimit(lower_limit_setpoint_q),
		.criticalLimit(critical_limit_setpoint_q),
		.hysteresisValue(hyst_q[`HYST_MSB:0]),
		.cmpMode(cmpMode),
		.shutdown(shutdown),
		.regReadPulse(regReadPulse),
		.limitAlert_q(limitAlert),
		.critAlert_q(critAlert)
	);

	// open drain: pin pulled low when active (low polarity)
	assign intOut = 1'b0;
	assign critical_alert_out = 1'b0;

	always @(posedge ref_clk) begin
		if (!rstn) begin
			intOeN_q <= 1'b1;
			critOeN_q <= 1'b1;
		end else begin
			intOeN_q <= ~(limitAlert ^ config_q[`CFG_INT_POL_BIT]);
			critOeN_q <= ~(critAlert ^ config_q[`CFG_CT_POL_BIT]);
		end
	end

endmodule // temp_spi_port

`default_nettype wire

/* sim/temp_spi_props.sv */
// assertions on the pins of the sensor serial port
`default_nettype none
module temp_spi_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// serial pins
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdo_q,
	input wire logic sdoOeN_q,
	// measurement and alerts
	input wire logic tempValid,
	input wire logic intOeN_q,
	input wire logic critOeN_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sclkLast_q;
	logic csLast_q;
	logic [7:0] sinceFall_q;
	logic [7:0] sinceSel_q;
	logic [7:0] sinceValid_q;
	function automatic logic [7:0] age(input logic [7:0] v);
		return v + {7'h00, v != 8'hff};
	endfunction
	// ----------------------------------------------------------------
	// saturating ages of the last clock fall, select and sample
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		sclkLast_q <= sclk;
		csLast_q <= csN;
		if (!rstn) begin
			sinceFall_q <= 8'hff;
			sinceSel_q <= 8'hff;
			sinceValid_q <= 8'hff;
		end else begin
			sinceFall_q <= (sclkLast_q && !sclk) ? 8'h00 : age(sinceFall_q);
			sinceSel_q <= (csLast_q && !csN) ? 8'h00 : age(sinceSel_q);
			sinceValid_q <= tempValid ? 8'h00 : age(sinceValid_q);
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence selectEdge;
		csN ##1 !csN;
	endsequence
	sequence deselected;
		csN [*6];
	endsequence
	a_oe_on_select: assert property (selectEdge |-> ##[1:6] !sdoOeN_q)
		else $error("sdo not enabled after select");
	a_oe_release: assert property (deselected |-> sdoOeN_q)
		else $error("sdo enabled while deselected");
	a_quiet_deselected: assert property (deselected |-> $stable(sdo_q))
		else $error("sdo moved while deselected");
	// a change soon after a rise would mean the wrong edge is used
	a_sdo_on_fall: assert property ($changed(sdo_q) && !sdoOeN_q |->
		sinceFall_q <= 8'd4 || sinceSel_q <= 8'd4)
		else $error("sdo changed away from a clock fall");
	a_reset_idle: assert property ($rose(rstn) |->
		sdoOeN_q && intOeN_q && critOeN_q)
		else $error("pins active after reset");
	a_int_after_sample: assert property ($fell(intOeN_q) |->
		sinceValid_q <= 8'd4)
		else $error("limit alert without a sample");
	a_crit_after_sample: assert property ($fell(critOeN_q) |->
		sinceValid_q <= 8'd4)
		else $error("critical alert without a sample");
	a_int_release_cause: assert property ($rose(intOeN_q) |->
		!$past(csN, 6) || sinceValid_q <= 8'd4)
		else $error("limit alert released without cause");
endmodule // temp_spi_props
`default_nettype wire

/* sim/spi_master_model.sv */
// serial master model driving the sensor port pins
`default_nettype none
module spi_master_model (
	// clock
	input wire logic ref_clk,
	// serial pins
	output var logic csN,
	output var logic sclk,
	output var logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		csN = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// shifts n bits; hold keeps select low so a following command continues the frame
	task automatic xfer(input logic [47:0] tx, input int n, input bit hold,
		output logic [47:0] rx);
		rx = '0;
		csN <= 1'b0;
		waitClk(4);
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b0;
			sdi <= tx[i];
			waitClk(4);
			sclk <= 1'b1;
			// answer trails the fall by a few clocks, so take it late
			waitClk(3);
			rx = {rx[46:0], sdo};
			waitClk(1);
		end
		if (!hold) csN <= 1'b1;
		sdi <= ~sdi;
		waitClk(8);
	endtask
endmodule // spi_master_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench of the sensor serial port
`include "temp_spi_regs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// identification values, arbitrary
	localparam logic [4:0] MAKER = 5'h0b;
	localparam logic [2:0] REV = 3'h2;
	localparam int RST_WAIT = 50000;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] tempValue = 16'h0000;
	logic tempValid = 1'b0;
	wire logic csN, sclk, sdi, sdo_q, sdoOeN_q, intOut, intOeN_q;
	wire logic critical_alert_out, critOeN_q;
	logic [47:0] rx;
	int n_errors = 0;
	int checks = 0;
	logic [2:0] adr [6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [15:0] defVal [6] = '{`RST_CONFIG, {MAKER, REV}, `RST_CRIT,
		`RST_HYST, `RST_HIGH, `RST_LOW};
	temp_spi_port #(.MAKER_CODE(MAKER), .REVISION(REV)) i_temp_spi_port (
		.ref_clk(ref_clk), .rstn(rstn), .csN(csN), .sclk(sclk), .sdi(sdi),
		.sdo_q(sdo_q), .sdoOeN_q(sdoOeN_q), .tempValue(tempValue),
		.tempValid(tempValid), .intOut(intOut), .intOeN_q(intOeN_q),
		.critical_alert_out(critical_alert_out), .critOeN_q(critOeN_q));
	// a released output line shows the inverse of its last value
	spi_master_model i_spi_master_model (.ref_clk(ref_clk), .csN(csN),
		.sclk(sclk), .sdi(sdi), .sdo(sdoOeN_q ? ~sdo_q : sdo_q));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	function automatic int wid(input logic [2:0] a);
		return (a == 3'h2 || a == 3'h4 || a >= 3'h6) ? 16 : 8;
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pins(input logic i, input logic c);
		cmp({14'h0000, intOeN_q, critOeN_q}, {14'h0000, i, c});
	endtask
	task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
		int w;
		w = wid(a);
		i_spi_master_model.xfer(48'({2'b01, a, 3'b000}) << w, 8 + w, 1'b0,
			rx);
		cmp(w == 8 ? {8'h00, rx[7:0]} : rx[15:0], exp);
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		int w;
		w = wid(a);
		i_spi_master_model.xfer((48'({2'b00, a, 3'b000}) << w) |
			48'(w == 8 ? {8'h00, v[7:0]} : v), 8 + w, 1'b0, rx);
	endtask
	task automatic temp(input logic [15:0] v);
		tempValue <= v;
		tempValid <= 1'b1;
		@(posedge ref_clk);
		tempValid <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		foreach (adr[i]) rdChk(adr[i], defVal[i]);
		pins(1'b1, 1'b1);
		$display("test defaults done");
		temp(16'h2100);
		pins(1'b0, 1'b1);
		rdChk(3'h3, {MAKER, REV});
		pins(1'b1, 1'b1);
		temp(16'h1000);
		pins(1'b1, 1'b1);
		temp(16'h0400);
		pins(1'b0, 1'b1);
		wr(3'h1, 16'h0060);
		pins(1'b1, 1'b1);
		wr(3'h1, 16'h0010);
		temp(16'h2100);
		rdChk(3'h1, 16'h0010);
		pins(1'b0, 1'b1);
		temp(16'h1f00);
		pins(1'b0, 1'b1);
		wr(3'h1, 16'h0070);
		pins(1'b0, 1'b1);
		wr(3'h1, 16'h0010);
		temp(16'h1d00);
		pins(1'b1, 1'b1);
		temp(16'h4a00);
		pins(1'b0, 1'b0);
		$display("test alerts done");
		wr(3'h6, 16'h1234);
		rdChk(3'h6, 16'h1234);
		i_spi_master_model.xfer(48'h0000000030ab, 16, 1'b0, rx);
		rdChk(3'h6, 16'h1234);
		wr(3'h5, 16'h000f);
		rdChk(3'h5, 16'h000f);
		wr(3'h3, 16'h00ff);
		rdChk(3'h3, {MAKER, REV});
		i_spi_master_model.xfer(48'h3804_5a78_0000, 48, 1'b1, rx);
		cmp(rx[15:0], 16'h045a);
		$display("test frames done");
		i_spi_master_model.xfer('1, 32, 1'b0, rx);
		repeat (RST_WAIT) @(posedge ref_clk);
		pins(1'b1, 1'b1);
		rdChk(3'h6, `RST_HIGH);
		rdChk(3'h1, `RST_CONFIG);
		$display("test interface reset done");
		print_verdict();
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_errors++;
		print_verdict();
	end
endmodule // tb
bind temp_spi_port temp_spi_props i_temp_spi_props (.ref_clk(ref_clk),
	.rstn(rstn), .csN(csN), .sclk(sclk), .sdo_q(sdo_q),
	.sdoOeN_q(sdoOeN_q), .tempValid(tempValid), .intOeN_q(intOeN_q),
	.critOeN_q(critOeN_q));
`default_nettype wire
